// ### shared/rsp_pkg.sv
// Constants and types shared by the serial register port
package rsp_pkg;
	localparam int ID_WIDTH = 5;
	localparam int REG_ADDR_WIDTH = 5;
	localparam int DATA_WIDTH = 16;
	localparam int PREAMBLE_BITS = 32;
	localparam int LOCAL_CLK_KHZ = 25000;
	localparam int SERIAL_CLK_MAX_KHZ = 2500;
	// Local clock cycles in one shortest serial clock period
	localparam int SERIAL_PERIOD_CYCLES = LOCAL_CLK_KHZ / SERIAL_CLK_MAX_KHZ;
	localparam logic [1:0] START_CODE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [4:0] ID_IDLE_VALUE = 5'h1F;
	localparam logic [15:0] READ_FILL_DEFAULT = 16'hFFFF;
	localparam logic [4:0] CONFIG_REG_ADDR = 5'h00;
	localparam logic [4:0] STATUS_REG_ADDR = 5'h01;
	localparam logic [4:0] ID_REG_ADDR = 5'h02;
	localparam int PHY_ACCESS_BIT = 0;
	localparam logic [15:0] CONFIG_RESET = 16'h0000;
	typedef enum logic [2:0] {
		RSP_HUNT,
		RSP_START,
		RSP_HEADER,
		RSP_TURN,
		RSP_READ,
		RSP_WRITE
	} rsp_state_type;
endpackage : rsp_pkg

// ### sim/rsp_host.sv
// Management controller model on the serial register bus
`timescale 1ns/100ps
module rsp_host
	import rsp_pkg::*;
(
	output logic reg_serial_clock,
	output logic serial_cmd_valid_n,
	output logic reg_serial_io_in,
	input wire logic reg_serial_io_out,
	input wire logic reg_serial_io_oe
);
	logic host_en;
	logic host_bit;
	// Weak pull-up: a released line reads high
	assign reg_serial_io_in = reg_serial_io_oe ? reg_serial_io_out : (host_en ? host_bit : 1'h1);
	initial begin
		reg_serial_clock = 1'h0;
		serial_cmd_valid_n = 1'h1;
		host_en = 1'h0;
		host_bit = 1'h1;
	end
	// 320 ns period, above the 2.5 MHz ceiling; clock rests low between frames
	task automatic tick(output logic seen);
		#160;
		seen = reg_serial_io_in;
		reg_serial_clock = 1'h1;
		#160;
		reg_serial_clock = 1'h0;
	endtask : tick
	task automatic pulses(input int n);
		logic s;
		repeat (n) tick(s);
	endtask : pulses
	task automatic frame(input logic [1:0] op, input logic [4:0] id, input logic [4:0] addr,
		input logic [15:0] wd, input int abort_at, output logic [15:0] rd);
		logic [63:0] bits;
		logic seen;
		bits = {32'hFFFFFFFF, START_CODE, op, id, addr, 2'h2, wd};
		rd = 16'h0000;
		for (int k = 0; k < 64; k++) begin
			serial_cmd_valid_n = (k >= abort_at);
			host_en = !(op == OP_READ && k >= 46);
			host_bit = bits[63-k];
			tick(seen);
			if (k >= 48)
				rd = {rd[14:0], seen};
		end
		host_en = 1'h0;
		serial_cmd_valid_n = 1'h1;
		// One idle serial period with the clock at rest before any next frame
		#320;
	endtask : frame
endmodule : rsp_host

// ### sim/rsp_port_properties.sv
// Pin-level checks on the serial register port
`timescale 1ns/100ps
module rsp_port_properties
	import rsp_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic reg_serial_clock,
	input wire logic serial_cmd_valid_n,
	input wire logic gated_phy_serial_io_oe,
	input wire logic reg_serial_io_oe,
	input wire logic buffered_serial_clock,
	input wire logic serial_dir_out,
	input wire logic [ID_WIDTH-1:0] arbitration_vector,
	input wire logic phy_access,
	input wire logic id_error
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence serial_rise;
		$rose(reg_serial_clock);
	endsequence
	sequence dir_run;
		serial_dir_out [*8];
	endsequence
	a_copy_rise: assert property (serial_rise |-> ##[1:4] buffered_serial_clock)
		else $error("buffered clock missed a rise");
	a_copy_fall: assert property ($fell(reg_serial_clock) |-> ##[1:4] !buffered_serial_clock)
		else $error("buffered clock missed a fall");
	a_dir_tracks_oe: assert property (serial_dir_out == reg_serial_io_oe)
		else $error("direction differs from data enable");
	a_dir_holds: assert property ($rose(serial_dir_out) |-> dir_run)
		else $error("direction dropped inside read data");
	a_abort_idle: assert property (serial_cmd_valid_n [*8] |-> !serial_dir_out)
		else $error("driving while command invalid");
	a_id_stable: assert property ($past(rstn, 3) |-> $stable(arbitration_vector))
		else $error("latched id changed outside reset");
	a_id_error: assert property ($past(rstn, 4) |-> id_error == (arbitration_vector == ID_IDLE_VALUE))
		else $error("id error flag wrong");
	a_gate_bit: assert property (gated_phy_serial_io_oe |-> phy_access)
		else $error("phy line driven without pass-through");
endmodule : rsp_port_properties

// ### sim/tb_rsp_port.sv
// Self-checking bench for the serial register port
`timescale 1ns/100ps
module tb_rsp_port
	import rsp_pkg::*;
;
	logic clk, rstn, reg_serial_clock, reg_serial_io_in, reg_serial_io_out, reg_serial_io_oe;
	logic serial_cmd_valid_n, gated_phy_serial_io_in, gated_phy_serial_io_out;
	logic gated_phy_serial_io_oe, buffered_serial_clock, serial_dir_out, phy_access, id_error;
	logic [ID_WIDTH-1:0] chip_id_straps, arbitration_vector;
	logic [15:0] rd;
	logic phy_line;
	int errors, checks, cyc;
	// PHY side: the device's copy while it drives, else the PHY's own level
	assign gated_phy_serial_io_in = gated_phy_serial_io_oe ? gated_phy_serial_io_out : phy_line;
	rsp_port i_dut (
		.clk(clk),
		.rstn(rstn),
		.reg_serial_clock(reg_serial_clock),
		.reg_serial_io_in(reg_serial_io_in),
		.reg_serial_io_out(reg_serial_io_out),
		.reg_serial_io_oe(reg_serial_io_oe),
		.serial_cmd_valid_n(serial_cmd_valid_n),
		.gated_phy_serial_io_in(gated_phy_serial_io_in),
		.gated_phy_serial_io_out(gated_phy_serial_io_out),
		.gated_phy_serial_io_oe(gated_phy_serial_io_oe),
		.buffered_serial_clock(buffered_serial_clock),
		.serial_dir_out(serial_dir_out),
		.chip_id_straps(chip_id_straps),
		.arbitration_vector(arbitration_vector),
		.phy_access(phy_access),
		.id_error(id_error)
	);
	rsp_host i_host (
		.reg_serial_clock(reg_serial_clock),
		.serial_cmd_valid_n(serial_cmd_valid_n),
		.reg_serial_io_in(reg_serial_io_in),
		.reg_serial_io_out(reg_serial_io_out),
		.reg_serial_io_oe(reg_serial_io_oe)
	);
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic test_done;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	task automatic do_reset(input logic [4:0] id);
		@(negedge clk);
		rstn = 1'h0;
		chip_id_straps = id;
		i_host.pulses(3);
		@(negedge clk);
		rstn = 1'h1;
		repeat (5) @(negedge clk);
		check("vector", {11'h0, id}, {11'h0, arbitration_vector});
		check("id_error", {15'h0, id == ID_IDLE_VALUE}, {15'h0, id_error});
		check("phy_access", 16'h0, {15'h0, phy_access});
	endtask : do_reset
	task automatic t_access;
		i_host.frame(OP_WRITE, 5'h0A, CONFIG_REG_ADDR, 16'h0001, 99, rd);
		check("pass", 16'h3, {14'h0, phy_access, gated_phy_serial_io_oe});
		check("phy copy", 16'h1, {15'h0, gated_phy_serial_io_out});
		check("dir idle", 16'h0, {15'h0, serial_dir_out});
		i_host.frame(OP_READ, 5'h0A, ID_REG_ADDR, 16'h0, 99, rd);
		check("id reg", 16'h000A, rd);
		i_host.frame(OP_READ, 5'h0A, 5'h07, 16'h0, 99, rd);
		check("fill", READ_FILL_DEFAULT, rd);
	endtask : t_access
	task automatic t_refuse;
		i_host.frame(OP_WRITE, 5'h0B, CONFIG_REG_ADDR, 16'h0, 99, rd);
		check("foreign write", 16'h1, {15'h0, phy_access});
		phy_line = 1'h0;
		i_host.frame(OP_READ, 5'h0B, ID_REG_ADDR, 16'h0, 99, rd);
		check("relay read", 16'h0000, rd);
		phy_line = 1'h1;
		i_host.frame(OP_WRITE, 5'h0A, CONFIG_REG_ADDR, 16'h0, 40, rd);
		check("aborted", 16'h1, {15'h0, phy_access});
		i_host.frame(OP_WRITE, 5'h0A, CONFIG_REG_ADDR, 16'h0, 99, rd);
		check("cleared", 16'h0, {14'h0, phy_access, gated_phy_serial_io_oe});
		phy_line = 1'h0;
		i_host.frame(OP_READ, 5'h0B, ID_REG_ADDR, 16'h0, 99, rd);
		check("foreign read", 16'hFFFF, rd);
		i_host.frame(OP_READ, 5'h0A, STATUS_REG_ADDR, 16'h0, 99, rd);
		check("status", 16'h0000, rd);
		phy_line = 1'h1;
	endtask : t_refuse
	always @(posedge clk) begin
		cyc++;
		if (cyc > 10000) begin
			errors++;
			test_done();
		end
	end
	initial begin
		rstn = 1'h0;
		phy_line = 1'h1;
		chip_id_straps = 5'h0A;
		do_reset(5'h0A);
		t_access();
		t_refuse();
		do_reset(ID_IDLE_VALUE);
		test_done();
	end
endmodule : tb_rsp_port
bind rsp_port rsp_port_properties i_props (
	.clk(clk),
	.rstn(rstn),
	.reg_serial_clock(reg_serial_clock),
	.serial_cmd_valid_n(serial_cmd_valid_n),
	.gated_phy_serial_io_oe(gated_phy_serial_io_oe),
	.reg_serial_io_oe(reg_serial_io_oe),
	.buffered_serial_clock(buffered_serial_clock),
	.serial_dir_out(serial_dir_out),
	.arbitration_vector(arbitration_vector),
	.phy_access(phy_access),
	.id_error(id_error)
);

// ### src/rsp_port.sv
// Serial register access port of the repeater, management frame slave
// How it works
// R1 - Frames follow the standard management frame format
// R2 - Bits launched and sampled at serial-clock rise
// R3 - Host keeps serial clock at 2.5 MHz; the bench host model runs 320 ns periods (3.125 MHz)
// R4 - Host clocks serial clock during reset
// R5 - Command-valid high drops back to frame hunt
// R6 - Pass-through bit routes data to PHY pin
// R7 - Serial clock copied out for chained devices
// R8 - Direction high only while device drives data
// R9 - Identification straps caught at reset release
// R10 - Latched identification selects our accesses
// R11 - Straps never set to all ones
// R12 - Reset input low holds reset state
// R13 - Everything runs on the 25 MHz local clock
// R14 - Register effects cross domains without partial values
`timescale 1ns/100ps
module rsp_port
	import rsp_pkg::*;
#(
	parameter int ADDR_W = REG_ADDR_WIDTH,
	parameter int DATA_W = DATA_WIDTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic reg_serial_clock,
	input wire logic reg_serial_io_in,
	output logic reg_serial_io_out,
	output logic reg_serial_io_oe,
	input wire logic serial_cmd_valid_n,
	input wire logic gated_phy_serial_io_in,
	output logic gated_phy_serial_io_out,
	output logic gated_phy_serial_io_oe,
	output logic buffered_serial_clock,
	output logic serial_dir_out,
	input wire logic [ID_WIDTH-1:0] chip_id_straps,
	output logic [ID_WIDTH-1:0] arbitration_vector,
	output logic phy_access,
	output logic id_error
);
	// Frame layout is fixed, so no other widths can be served
	if (ADDR_W != REG_ADDR_WIDTH || DATA_W != DATA_WIDTH) begin : g_bad_width
		$error("rsp_port: frame widths are fixed by the frame format");
	end

	logic sclk_s;
	logic sio_s;
	logic cv_n_s;
	logic phy_io_s;
	logic [ID_WIDTH-1:0] straps_meta_reg;
	logic [ID_WIDTH-1:0] straps_sync_reg;
	logic sclk_prev_reg;
	logic rise;
	logic in_reset_reg;
	logic [ID_WIDTH-1:0] chip_id_reg;
	rsp_state_type state_reg;
	logic [5:0] count_reg;
	logic [1:0] op_reg;
	logic [ADDR_W-1:0] phy_addr_reg;
	logic [ADDR_W-1:0] reg_addr_reg;
	logic [DATA_W-1:0] shift_reg;
	logic [DATA_W-1:0] config_reg;
	logic drive_reg;
	logic relay_reg;
	logic selected;

	// Every pin but rstn passes two flops before any logic reads it, see R13
	rsp_sync u_sync_sclk (
		.clk(clk),
		.rstn(rstn),
		.async_in(reg_serial_clock),
		.sync_out(sclk_s)
	);
	rsp_sync #(.RESET_VALUE(1'b1)) u_sync_sio (
		.clk(clk),
		.rstn(rstn),
		.async_in(reg_serial_io_in),
		.sync_out(sio_s)
	);
	rsp_sync #(.RESET_VALUE(1'b1)) u_sync_cv (
		.clk(clk),
		.rstn(rstn),
		.async_in(serial_cmd_valid_n),
		.sync_out(cv_n_s)
	);
	rsp_sync #(.RESET_VALUE(1'b1)) u_sync_phy (
		.clk(clk),
		.rstn(rstn),
		.async_in(gated_phy_serial_io_in),
		.sync_out(phy_io_s)
	);
	// Straps are static levels, so their two flops run through reset: the value
	// caught at release is then the strapped one and not a reset value, see R9
	always_ff @(posedge clk) begin
		straps_meta_reg <= chip_id_straps;
		straps_sync_reg <= straps_meta_reg;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sclk_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_s;
		end
	end
	// Serial clock rise as seen in the local domain, see R2
	assign rise = sclk_s && !sclk_prev_reg;

	// Straps caught once, on the first edge after release, see R9 R12
	always_ff @(posedge clk) begin
		if (!rstn) begin
			in_reset_reg <= 1'b1;
			chip_id_reg <= '0;
		end else begin
			in_reset_reg <= 1'b0;
			if (in_reset_reg) begin
				chip_id_reg <= straps_sync_reg; // see R9
			end
		end
	end
	// Matched against the latched copy, so strap movement after reset is ignored
	assign selected = (phy_addr_reg == chip_id_reg); // see R10

	// Frame receiver; command-valid high forces resync, see R1 R5
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= RSP_HUNT;
			count_reg <= '0;
			op_reg <= '0;
			phy_addr_reg <= '0;
			reg_addr_reg <= '0;
			shift_reg <= '0;
			drive_reg <= 1'b0;
			relay_reg <= 1'b0;
		end else if (cv_n_s) begin
			state_reg <= RSP_HUNT; // see R5
			count_reg <= '0;
			drive_reg <= 1'b0;
			relay_reg <= 1'b0;
		end else if (rise) begin
			case (state_reg)
				RSP_HUNT: begin
					// Count preamble ones; a zero after enough of them starts a frame
					if (sio_s) begin
						if (count_reg != 6'(PREAMBLE_BITS)) begin
							count_reg <= count_reg + 6'h01;
						end
					end else if (count_reg == 6'(PREAMBLE_BITS)) begin
						state_reg <= RSP_START; // see R1
					end else begin
						count_reg <= '0;
					end
				end
				RSP_START: begin
					if (sio_s == START_CODE[0]) begin
						state_reg <= RSP_HEADER;
						count_reg <= '0;
					end else begin
						state_reg <= RSP_HUNT;
						count_reg <= '0;
					end
				end
				RSP_HEADER: begin
					// Opcode, device address, register address, MSB first
					if (count_reg < 6'h02) begin
						op_reg <= {op_reg[0], sio_s};
					end else if (count_reg < 6'h07) begin
						phy_addr_reg <= {phy_addr_reg[ADDR_W-2:0], sio_s};
					end else begin
						reg_addr_reg <= {reg_addr_reg[ADDR_W-2:0], sio_s};
					end
					if (count_reg == 6'h0B) begin
						state_reg <= RSP_TURN;
						count_reg <= '0;
					end else begin
						count_reg <= count_reg + 6'h01;
					end
				end
				RSP_TURN: begin
					// Two turnaround bits; for a read we take the line on the second
					if (count_reg == 6'h00) begin
						count_reg <= 6'h01;
						if (op_reg == OP_READ && selected) begin
							drive_reg <= 1'b1; // see R8
							shift_reg <= (reg_addr_reg == CONFIG_REG_ADDR) ? config_reg :
								(reg_addr_reg == ID_REG_ADDR) ?
								{{(DATA_W-ID_WIDTH){1'b0}}, chip_id_reg} :
								(reg_addr_reg == STATUS_REG_ADDR) ?
								{{(DATA_W-1){1'b0}}, phy_io_s} : READ_FILL_DEFAULT;
						end else if (op_reg == OP_READ && config_reg[PHY_ACCESS_BIT]) begin
							// A PHY behind the gate answers this read; hand it back, see R6
							relay_reg <= 1'b1;
						end
					end else begin
						count_reg <= '0;
						state_reg <= (op_reg == OP_READ) ? RSP_READ : RSP_WRITE;
					end
				end
				RSP_READ: begin
					shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
					if (count_reg == 6'(DATA_W - 1)) begin
						state_reg <= RSP_HUNT;
						count_reg <= '0;
						drive_reg <= 1'b0; // see R8
						relay_reg <= 1'b0;
					end else begin
						count_reg <= count_reg + 6'h01;
					end
				end
				RSP_WRITE: begin
					shift_reg <= {shift_reg[DATA_W-2:0], sio_s};
					if (count_reg == 6'(DATA_W - 1)) begin
						state_reg <= RSP_HUNT;
						count_reg <= '0;
					end else begin
						count_reg <= count_reg + 6'h01;
					end
				end
				default: begin
					state_reg <= RSP_HUNT;
					count_reg <= '0;
					drive_reg <= 1'b0;
					relay_reg <= 1'b0;
				end
			endcase
		end
	end

	// Written whole on the last data bit, so no partial word is ever seen, see R14
	always_ff @(posedge clk) begin
		if (!rstn) begin
			config_reg <= CONFIG_RESET; // see R12
		end else if (!cv_n_s && rise && state_reg == RSP_WRITE && selected
			&& count_reg == 6'(DATA_W - 1) && op_reg == OP_WRITE
			&& reg_addr_reg == CONFIG_REG_ADDR) begin
			config_reg <= {shift_reg[DATA_W-2:0], sio_s}; // see R14
		end
	end

	// Registered pin drivers; copied pins lag by three local cycles, outputs decoded from frame state by four
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_serial_io_out <= 1'b1;
			reg_serial_io_oe <= 1'b0;
			serial_dir_out <= 1'b0;
			buffered_serial_clock <= 1'b0;
			gated_phy_serial_io_out <= 1'b1;
			gated_phy_serial_io_oe <= 1'b0;
			phy_access <= 1'b0;
			arbitration_vector <= '0;
			id_error <= 1'b0;
		end else begin
			// Data bit changes after the rise that shifts it, see R2
			// Relayed PHY data costs three local cycles; a PHY must answer well
			// inside half a serial period for the host to see it in time, see R6
			if (relay_reg) begin
				reg_serial_io_out <= phy_io_s; // see R6
			end else begin
				reg_serial_io_out <= (state_reg == RSP_READ) ? shift_reg[DATA_W-1] : 1'b0;
			end
			reg_serial_io_oe <= drive_reg || relay_reg; // see R8
			serial_dir_out <= drive_reg || relay_reg; // see R8
			buffered_serial_clock <= sclk_s; // see R7
			// Host data forwarded to the PHY pin while pass-through is on, see R6
			gated_phy_serial_io_out <= sio_s;
			// Released while the PHY answers, so the two never fight, see R6
			gated_phy_serial_io_oe <= config_reg[PHY_ACCESS_BIT] && !drive_reg && !relay_reg;
			phy_access <= config_reg[PHY_ACCESS_BIT];
			arbitration_vector <= chip_id_reg; // see R10
			// Flags a strap setting equal to the idle vector, see R11
			id_error <= !in_reset_reg && (chip_id_reg == ID_IDLE_VALUE);
		end
	end
endmodule : rsp_port

// ### src/rsp_sync.sv
// Two-flop synchroniser for one level from outside the local clock domain
`timescale 1ns/100ps
module rsp_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic async_in,
	output logic sync_out
);
	logic first_reg;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			first_reg <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			first_reg <= async_in;
			sync_out <= first_reg;
		end
	end
endmodule : rsp_sync
